// ===== rtl/vcd_glitch_filter.sv
// Purpose: rejects pulses shorter than the glitch window on a bus line
// Assumes: din synchronous to clk
// Notes:   output moves after STABLE_CYC equal differing samples
`timescale 1ns/1ps
`include "vcd_params.svh"

module vcd_glitch_filter #(
    parameter int unsigned STABLE_CYC = `VCD_TG_CYC
) (
    input  wire logic clk,
    input  wire logic reset,
    input  wire logic din,
    output logic      dout
);
    localparam int unsigned CW = $clog2(STABLE_CYC + 1);

    logic [CW-1:0] cnt_r;
    logic          dout_r;

    always_ff @(posedge clk) begin
        if (reset) begin
            cnt_r  <= '0;
            dout_r <= `VCD_LINE_IDLE;
        end else if (din == dout_r) begin
            cnt_r  <= '0;
        end else if (cnt_r == CW'(STABLE_CYC - 1)) begin
            cnt_r  <= '0;
            dout_r <= din;
        end else begin
            cnt_r  <= cnt_r + 1'b1;
        end
    end

    assign dout = dout_r;

endmodule

// ===== rtl/vcd_i2c_slave.sv
// Purpose: write-only two-wire bus slave of the voice coil driver
// Assumes: scl_i and sda_i synchronous to clk; pad logic resolves sda
// Notes:   registers live outside; this block emits one write per data byte
//
// Notes on behaviour
// - answer bus address 7'h0c by default, address is a parameter
// - slave only; handles SCL up to 400 kHz and 1000 kHz
// - SDA moves only while SCL is low, except start and stop
// - start is SDA falling while SCL high
// - stop is SDA rising while SCL high
// - repeated start acts as start; bus stays busy
// - units of nine bits: eight data MSB first, then acknowledge
// - receiver acknowledges by holding SDA low on ninth pulse
// - any number of bytes between start and stop
// - acknowledge an address byte that matches our address and carries the write flag
// - register address byte follows and is acknowledged
// - each data byte acknowledged and written to addressed register
// - register address increments after every data byte
// - optional reset clears registers when both lines held low long
`timescale 1ns/1ps
`include "vcd_params.svh"

module vcd_i2c_slave #(
    parameter logic [6:0]  DEV_ADDR = `VCD_DEV_ADDR,
    parameter int unsigned TG_CYC   = `VCD_TG_CYC,
    parameter int unsigned HSD_CYC  = `VCD_THSD_CYC
) (
    input  wire logic     clk,
    input  wire logic     reset,
    input  wire logic     scl_i,
    input  wire logic     sda_i,
    output logic          sda_o,
    output logic          sda_oe,
    input  wire logic     hw_reset_en,
    output vcd_pkg::vcd_wr_s wr,
    output logic          bus_busy,
    output logic          regs_clear
);
    import vcd_pkg::*;

    localparam int unsigned HW = $clog2(HSD_CYC + 1);

    logic          scl_f;
    logic          sda_f;
    logic          scl_q;
    logic          sda_q;
    logic          scl_rise;
    logic          scl_fall;
    logic          start_det;
    logic          stop_det;
    logic          active;
    logic          byte_done;
    logic          ack_end;
    logic          addr_match;
    vcd_state_e    state_r;
    logic [3:0]    bit_cnt_r;
    logic          ack_phase_r;
    logic [7:0]    shift_r;
    logic          sda_oe_r;
    logic          sda_o_r;
    logic [7:0]    ptr_r;
    vcd_wr_s       wr_r;
    logic          busy_r;
    logic [HW-1:0] hsd_cnt_r;
    logic          clear_r;

    // slave only: scl is never driven, filter lag fits 1 MHz
    // line filters reject short spikes on both wires
    vcd_glitch_filter #(
        .STABLE_CYC (TG_CYC)
    ) u_scl_filt (
        .clk   (clk),
        .reset (reset),
        .din   (scl_i),
        .dout  (scl_f)
    );

    vcd_glitch_filter #(
        .STABLE_CYC (TG_CYC)
    ) u_sda_filt (
        .clk   (clk),
        .reset (reset),
        .din   (sda_i),
        .dout  (sda_f)
    );

    always_ff @(posedge clk) begin
        if (reset) begin
            scl_q <= `VCD_LINE_IDLE;
            sda_q <= `VCD_LINE_IDLE;
        end else begin
            scl_q <= scl_f;
            sda_q <= sda_f;
        end
    end

    assign scl_rise  = scl_f & ~scl_q;
    assign scl_fall  = ~scl_f & scl_q;
    assign start_det = scl_f & scl_q & sda_q & ~sda_f;
    assign stop_det  = scl_f & scl_q & ~sda_q & sda_f;

    assign active = (state_r == ST_ADDR) || (state_r == ST_REG) ||
                    (state_r == ST_DATA);

    assign byte_done = scl_fall & active & ~ack_phase_r &
                       (bit_cnt_r == `VCD_BITS);
    assign ack_end   = scl_fall & ack_phase_r;

    assign addr_match = (shift_r[7:1] == DEV_ADDR) &&
                        (shift_r[0] == `VCD_RW_WRITE);

    // protocol engine: framing, acknowledge and sda drive
    always_ff @(posedge clk) begin
        if (reset || clear_r) begin
            state_r     <= ST_IDLE;
            bit_cnt_r   <= '0;
            ack_phase_r <= 1'b0;
            shift_r     <= '0;
            sda_oe_r    <= 1'b0;
        end else if (start_det) begin
            state_r     <= ST_ADDR;
            bit_cnt_r   <= '0;
            ack_phase_r <= 1'b0;
            sda_oe_r    <= 1'b0;
        end else if (stop_det) begin
            state_r     <= ST_IDLE;
            bit_cnt_r   <= '0;
            ack_phase_r <= 1'b0;
            sda_oe_r    <= 1'b0;
        end else begin
            // data sampled on rising scl, msb first
            if (scl_rise && active && !ack_phase_r &&
                bit_cnt_r != `VCD_BITS) begin
                shift_r   <= {shift_r[6:0], sda_f};
                bit_cnt_r <= bit_cnt_r + 1'b1;
            end
            // drive changes only on falling scl
            if (byte_done) begin
                ack_phase_r <= 1'b1;
                case (state_r)
                    ST_ADDR: begin
                        if (addr_match) begin
                            sda_oe_r <= 1'b1;
                            state_r  <= ST_REG;
                        end else begin
                            sda_oe_r <= 1'b0;
                            state_r  <= ST_IGNORE;
                        end
                    end
                    ST_REG: begin
                        sda_oe_r <= 1'b1;
                        state_r  <= ST_DATA;
                    end
                    ST_DATA: begin
                        sda_oe_r <= 1'b1;
                    end
                    default: begin
                        sda_oe_r <= 1'b0;
                    end
                endcase
            end else if (ack_end) begin
                // release after ninth pulse
                sda_oe_r    <= 1'b0;
                ack_phase_r <= 1'b0;
                bit_cnt_r   <= '0;
            end
        end
    end

    // only a low level is ever driven
    always_ff @(posedge clk) begin
        if (reset) begin
            sda_o_r <= `VCD_DRIVE_LVL;
        end else begin
            sda_o_r <= `VCD_DRIVE_LVL;
        end
    end

    // register pointer and write strobe
    always_ff @(posedge clk) begin
        if (reset || clear_r) begin
            ptr_r <= `VCD_PTR_RST;
            wr_r  <= '0;
        end else begin
            wr_r.valid <= 1'b0;
            if (byte_done && state_r == ST_REG) begin
                ptr_r <= shift_r;
            end else if (byte_done && state_r == ST_DATA) begin
                wr_r.valid <= 1'b1;
                wr_r.addr  <= ptr_r;
                wr_r.data  <= shift_r;
                ptr_r      <= ptr_r + 1'b1;
            end
        end
    end

    // busy from start (or repeated start) until stop
    always_ff @(posedge clk) begin
        if (reset || clear_r) begin
            busy_r <= 1'b0;
        end else if (start_det) begin
            busy_r <= 1'b1;
        end else if (stop_det) begin
            busy_r <= 1'b0;
        end
    end

    // both lines low for the hold time clears the registers
    always_ff @(posedge clk) begin
        if (reset) begin
            hsd_cnt_r <= '0;
            clear_r   <= 1'b0;
        end else if (hw_reset_en && !scl_f && !sda_f) begin
            if (hsd_cnt_r == HW'(HSD_CYC)) begin
                clear_r <= 1'b1;
            end else begin
                hsd_cnt_r <= hsd_cnt_r + 1'b1;
            end
        end else begin
            hsd_cnt_r <= '0;
            clear_r   <= 1'b0;
        end
    end

    assign sda_o      = sda_o_r;
    assign sda_oe     = sda_oe_r;
    assign wr         = wr_r;
    assign bus_busy   = busy_r;
    assign regs_clear = clear_r;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    a_drive_on_fall: assert property (
        $changed(sda_oe_r) |-> $past(scl_fall) || $past(start_det) ||
                               $past(stop_det) || $past(clear_r))
        else $error("sda drive changed while scl high");

    a_start_frame: assert property (
        start_det && !clear_r |=> state_r == ST_ADDR && bit_cnt_r == 4'h0
                                  && busy_r)
        else $error("start did not open an address frame");

    a_stop_release: assert property (
        stop_det && !start_det && !clear_r |=>
            state_r == ST_IDLE && !sda_oe_r && !busy_r)
        else $error("stop did not release the bus");

    a_ack_match: assert property (
        byte_done && state_r == ST_ADDR && addr_match && !clear_r |=>
            sda_oe_r && state_r == ST_REG)
        else $error("matching address not acknowledged");

    a_miss_quiet: assert property (
        state_r == ST_IGNORE && !start_det && !clear_r |=>
            !sda_oe_r && state_r != ST_ADDR)
        else $error("ignored transfer drove sda");

    a_ack_ninth: assert property (
        sda_oe_r |-> ack_phase_r && bit_cnt_r == `VCD_BITS)
        else $error("sda driven outside acknowledge slot");

    a_write_byte: assert property (
        byte_done && state_r == ST_DATA && !clear_r |=>
            wr_r.valid && wr_r.data == $past(shift_r) &&
            wr_r.addr == $past(ptr_r))
        else $error("data byte not written");

    a_data_chain: assert property (
        byte_done && state_r == ST_DATA && !clear_r |=>
            state_r == ST_DATA && sda_oe_r)
        else $error("data byte ended the write chain");

    a_reg_ack: assert property (
        byte_done && state_r == ST_REG && !clear_r |=>
            sda_oe_r && state_r == ST_DATA && ptr_r == $past(shift_r))
        else $error("register address not acknowledged");

    a_ptr_incr: assert property (
        wr_r.valid |-> ptr_r == wr_r.addr + 8'h01)
        else $error("register pointer did not advance");

    a_hw_clear: assert property (
        clear_r |-> $past(hw_reset_en) && !$past(scl_f) && !$past(sda_f)
                    && hsd_cnt_r == HW'(HSD_CYC))
        else $error("register clear without held-low lines");

    a_low_only: assert property (
        sda_o_r == `VCD_DRIVE_LVL)
        else $error("sda driven high");

    c_write: cover property (wr_r.valid ##[1:1000] wr_r.valid);
    c_nack: cover property (state_r == ST_ADDR ##1 state_r == ST_IGNORE);
    c_restart: cover property (busy_r && start_det);
    c_clear: cover property ($rose(clear_r));
    c_reg_ack: cover property (byte_done && state_r == ST_REG);

endmodule

// ===== rtl/vcd_params.svh
// Purpose: named constants of the voice coil driver bus front end
// Assumes: 125 MHz system clock
// Notes:   times in ns, cycle counts derived from them
`ifndef VCD_PARAMS_SVH
`define VCD_PARAMS_SVH

`define VCD_CLK_NS    8
`define VCD_TG_NS     50
`define VCD_THSD_NS   2000000
// glitch window is a longest time: round down
`define VCD_TG_CYC    (`VCD_TG_NS / `VCD_CLK_NS)
// reset hold time is a least time: round up
`define VCD_THSD_CYC  ((`VCD_THSD_NS + `VCD_CLK_NS - 1) / `VCD_CLK_NS)

`define VCD_DEV_ADDR  7'h0c
`define VCD_RW_WRITE  1'h0
`define VCD_BITS      4'h8
`define VCD_LINE_IDLE 1'h1
`define VCD_PTR_RST   8'h00
`define VCD_DRIVE_LVL 1'h0

`endif

// ===== rtl/vcd_pkg.sv
// Purpose: types shared by the bus front end
// Assumes: constants come from vcd_params.svh
// Notes:   none
package vcd_pkg;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'h0,
        ST_ADDR   = 3'h1,
        ST_REG    = 3'h2,
        ST_DATA   = 3'h3,
        ST_IGNORE = 3'h4
    } vcd_state_e;

    typedef struct packed {
        logic       valid;
        logic [7:0] addr;
        logic [7:0] data;
    } vcd_wr_s;

endpackage

// ===== tb/tb_vcd_i2c_slave.sv
// Purpose: self-checking bench of the write-only bus slave
// Assumes: small clear hold count for a short run
// Notes:   write strobes are checked against a queue of notes
`timescale 1ns/1ps

module tb_vcd_i2c_slave;
    import vcd_pkg::*;

    localparam int HSD = 20;

    logic        clk = 1'h0;
    logic        reset = 1'h1;
    logic        hw_reset_en = 1'h0;
    logic        scl;
    logic        sda_m;
    wire logic   sda;
    logic        sda_o;
    logic        sda_oe;
    vcd_wr_s     wr;
    logic        bus_busy;
    logic        regs_clear;
    logic [15:0] notes[$];
    int          num_errors = 0;
    int          total_checks = 0;

    always #4 clk = ~clk;

    // open-drain wire: pulled low by either party, else pull-up
    assign sda = (sda_oe ? sda_o : 1'h1) & sda_m;

    vcd_i2c_slave #(.HSD_CYC(HSD)) i_vcd_i2c_slave (
        .clk        (clk),
        .reset      (reset),
        .scl_i      (scl),
        .sda_i      (sda),
        .sda_o      (sda_o),
        .sda_oe     (sda_oe),
        .hw_reset_en(hw_reset_en),
        .wr         (wr),
        .bus_busy   (bus_busy),
        .regs_clear (regs_clear)
    );

    vcd_i2c_master i_vcd_i2c_master (
        .clk  (clk),
        .sda  (sda),
        .scl  (scl),
        .sda_m(sda_m)
    );

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("Error t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // ok says whether the slave should acknowledge and store the bytes
    task automatic write_seq(input logic [7:0] ab, input logic [7:0] ra,
                             input int n, input logic ok);
        logic       a;
        logic [7:0] d;
        i_vcd_i2c_master.send_byte(ab, a);
        chk({15'h0, a}, {15'h0, ~ok});
        i_vcd_i2c_master.send_byte(ra, a);
        chk({15'h0, a}, {15'h0, ~ok});
        for (int i = 0; i < n; i++) begin
            d = 8'($urandom);
            if (ok) begin
                notes.push_back({ra, d});
            end
            i_vcd_i2c_master.send_byte(d, a);
            chk({15'h0, a}, {15'h0, ~ok});
            ra = ra + 8'h01;
        end
    endtask

    always @(posedge clk) begin
        if (wr.valid === 1'h1) begin
            if (notes.size() == 0) begin
                chk({wr.addr, wr.data}, 16'hxxxx);
            end else begin
                chk({wr.addr, wr.data}, notes.pop_front());
            end
        end
    end

    initial begin
        repeat (40000) @(posedge clk);
        num_errors++;
        finish_test();
    end

    initial begin
        void'($urandom(8));
        repeat (5) @(posedge clk);
        reset <= 1'h0;
        repeat (4) @(posedge clk);
        i_vcd_i2c_master.start_c();
        chk({15'h0, bus_busy}, 16'h0001);
        write_seq(8'h18, 8'hfe, 3, 1'h1);
        i_vcd_i2c_master.stop_c();
        chk({15'h0, bus_busy}, 16'h0000);
        i_vcd_i2c_master.start_c();
        write_seq(8'h1a, 8'h33, 2, 1'h0);
        i_vcd_i2c_master.stop_c();
        i_vcd_i2c_master.start_c();
        write_seq(8'h19, 8'h05, 1, 1'h0);
        i_vcd_i2c_master.stop_c();
        i_vcd_i2c_master.start_c();
        write_seq(8'h18, 8'h40, 1, 1'h1);
        i_vcd_i2c_master.start_c();
        chk({15'h0, bus_busy}, 16'h0001);
        write_seq(8'h18, 8'h80, 2, 1'h1);
        i_vcd_i2c_master.stop_c();
        i_vcd_i2c_master.hold_low(2 * HSD);
        chk({15'h0, regs_clear}, 16'h0000);
        i_vcd_i2c_master.stop_c();
        hw_reset_en <= 1'h1;
        i_vcd_i2c_master.hold_low(2 * HSD);
        chk({15'h0, regs_clear}, 16'h0001);
        i_vcd_i2c_master.stop_c();
        chk({15'h0, regs_clear}, 16'h0000);
        i_vcd_i2c_master.start_c();
        write_seq(8'h18, 8'h10, 1, 1'h1);
        i_vcd_i2c_master.stop_c();
        repeat (20) @(posedge clk);
        chk(16'(notes.size()), 16'h0000);
        finish_test();
    end
endmodule

// ===== tb/vcd_i2c_master.sv
// Purpose: behavioural bus master that drives scl and its own sda pull
// Assumes: sda is the resolved wire, high when nobody pulls it low
// Notes:   lines move only just after a clk rising edge
`timescale 1ns/1ps

module vcd_i2c_master #(
    parameter int H = 16
) (
    input  wire logic clk,
    input  wire logic sda,
    output logic      scl,
    output logic      sda_m
);
    // only the master makes scl, start and stop
    initial begin
        scl   = 1'h1;
        sda_m = 1'h1;
    end

    task automatic wait_c(input int n);
        repeat (n) @(posedge clk);
    endtask

    // sda settles while scl is low and stays put through scl high
    task automatic clk_bit(input logic v, output logic s);
        wait_c(4);
        sda_m <= v;
        wait_c(H);
        scl <= 1'h1;
        wait_c(H);
        s = sda;
        scl <= 1'h0;
    endtask

    // sda falls while scl high; also serves as repeated start
    task automatic start_c();
        wait_c(4);
        sda_m <= 1'h1;
        wait_c(H);
        scl <= 1'h1;
        wait_c(H);
        sda_m <= 1'h0;
        wait_c(H);
        scl <= 1'h0;
    endtask

    // sda rises while scl high, releasing the bus
    task automatic stop_c();
        wait_c(4);
        sda_m <= 1'h0;
        wait_c(H);
        scl <= 1'h1;
        wait_c(H);
        sda_m <= 1'h1;
        wait_c(H);
    endtask

    // eight bits msb first, then released ninth bit read back
    // the first byte carries address and direction flag
    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(b[i], s);
        end
        clk_bit(1'h1, ack);
    endtask

    // both lines held low for n cycles
    task automatic hold_low(input int n);
        wait_c(4);
        sda_m <= 1'h0;
        wait_c(H);
        scl <= 1'h0;
        wait_c(n);
    endtask
endmodule
